// ---- bsfu_params.svh ----
// register offsets, flag positions, reset values and cycle counts
`ifndef BSFU_PARAMS_SVH
`define BSFU_PARAMS_SVH

// word-aligned byte offsets on the register bus
`define ADR_INSTR 9'h000
`define ADR_STATUS 9'h004
`define ADR_FLAGS 9'h008
`define ADR_SP 9'h00C
// address bits [8:7] pick the general and the i/o register windows
`define REGION_GPR 2'h1
`define REGION_IO 2'h2

// bit positions inside flags_q
`define FLAG_BORROW 3'h0
`define FLAG_ALL_LOW 3'h1
`define FLAG_MSB 3'h2
`define FLAG_COPY 3'h6

// reset values
`define FLAGS_RESET 8'h00
`define REG_RESET 8'h00

// execution length in core cycles
`define CYC_TWO 2
`define CYC_ONE 1

`endif

// ---- bsfu_pkg.sv ----
// types shared by the bit, shift and flag execution unit
`default_nettype none
package bsfu_pkg;

  // operation codes, hex values written out
  typedef enum logic [4:0] {
    stack_store_op = 5'h00,
    stack_load_op = 5'h01,
    io_bit_set_op = 5'h02,
    io_bit_clear_op = 5'h03,
    shift_left_op = 5'h04,
    shift_right_op = 5'h05,
    rotate_left_op = 5'h06,
    rotate_right_op = 5'h07,
    sign_shift_right_op = 5'h08,
    nibble_swap_op = 5'h09,
    copy_flag_to_reg_op = 5'h0A,
    flag_set_op = 5'h0B,
    flag_clear_op = 5'h0C,
    reg_to_copy_flag_op = 5'h0D,
    borrow_flag_set_op = 5'h0E,
    borrow_flag_clear_op = 5'h0F,
    msb_flag_set_op = 5'h10,
    msb_flag_clear_op = 5'h11,
    all_low_set_op = 5'h12,
    all_low_clear_op = 5'h13,
    no_op = 5'h1F
  } op_type;

  // one instruction word, 23 bits, op in the top field
  typedef struct packed {
    op_type op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [2:0] bit_sel;
    logic [4:0] io_addr;
  } instr_type;

  typedef enum logic [0:0] {
    st_idle = 1'b0,
    st_exec = 1'b1
  } state_type;

endpackage
`default_nettype wire

// ---- shift_unit.sv ----
// combinational shifter: shifts, rotates through borrow, nibble swap
`default_nettype none
module shift_unit
  import bsfu_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic [W-1:0] val,
  input wire logic cin,
  input wire op_type op,
  output logic [W-1:0] res,
  output logic cout
);

  // every other op passes the value through untouched
  always_comb begin
    res = val;
    cout = cin;
    case (op)
      shift_left_op: res = {val[W-2:0], 1'b0};
      shift_right_op: res = {1'b0, val[W-1:1]};
      rotate_left_op: begin
        res = {val[W-2:0], cin};
        cout = val[W-1];
      end
      rotate_right_op: begin
        res = {cin, val[W-1:1]};
        cout = val[0];
      end
      sign_shift_right_op: res = {val[W-1], val[W-1:1]};
      nibble_swap_op: res = {val[W/2-1:0], val[W-1:W/2]};
      default: res = val;
    endcase
  end

endmodule // shift_unit
`default_nettype wire

// ---- bit_modify.sv ----
// replaces one selected bit of a word, keeps all others
`default_nettype none
module bit_modify #(
  parameter int W = 8
) (
  input wire logic [W-1:0] val,
  input wire logic [$clog2(W)-1:0] idx,
  input wire logic fill,
  output logic [W-1:0] res
);

  // one bit forced, the rest copied
  always_comb begin
    res = val;
    res[idx] = fill;
  end

endmodule // bit_modify
`default_nettype wire

// ---- bit_shift_flag_unit.sv ----
// stack, bit, shift and flag execution unit with a wishbone slave
`include "bsfu_params.svh"
`default_nettype none
module bit_shift_flag_unit
  import bsfu_pkg::*;
#(
  parameter int STACK_DEPTH = 16
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [8:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic BUSY
);

  localparam int SPW = $clog2(STACK_DEPTH);

  logic [7:0] gpr_q [32];
  logic [7:0] io_q [32];
  logic [7:0] stack_q [STACK_DEPTH];
  logic [7:0] flags_q;
  logic [SPW-1:0] sp_q;
  instr_type ins_q;
  state_type state_q;
  logic [1:0] cnt_q;
  logic ack_q;
  logic [31:0] dat_q;

  // bus decode
  wire req = WB_CYC_I & WB_STB_I;
  wire wr_fire = req & WB_WE_I & ack_q;
  wire [8:0] word_adr = {WB_ADR_I[8:2], 2'b00};
  wire [4:0] wb_idx = WB_ADR_I[6:2];
  wire sel_instr = word_adr == `ADR_INSTR;
  wire sel_status = word_adr == `ADR_STATUS;
  wire sel_flags = word_adr == `ADR_FLAGS;
  wire sel_sp = word_adr == `ADR_SP;
  wire sel_gpr = WB_ADR_I[8:7] == `REGION_GPR;
  wire sel_io = WB_ADR_I[8:7] == `REGION_IO;
  wire busy = state_q != st_idle;
  // the instruction word needs its three low byte lanes
  wire start = wr_fire & sel_instr & (&WB_SEL_I[2:0]) & ~busy;
  // software pokes are refused while an op runs, no write conflict
  wire sw_we = wr_fire & WB_SEL_I[0] & ~busy;
  wire sw_gpr_we = sw_we & sel_gpr;
  wire sw_io_we = sw_we & sel_io;
  wire sw_flags_we = sw_we & sel_flags;

  // incoming instruction and its length
  wire instr_type new_ins = instr_type'(WB_DAT_I[22:0]);
  wire two_cyc = new_ins.op inside {stack_store_op, stack_load_op,
    io_bit_set_op, io_bit_clear_op};
  wire [1:0] cnt_load = two_cyc ? 2'(`CYC_TWO - 1) : 2'(`CYC_ONE - 1);
  wire commit = busy && cnt_q == 2'h0;
  wire op_type op = ins_q.op;

  // operands
  wire [7:0] rd_val = gpr_q[ins_q.rd];
  wire [7:0] rr_val = gpr_q[ins_q.rr];
  wire [7:0] io_val = io_q[ins_q.io_addr];
  wire [SPW-1:0] sp_minus = sp_q - 1'b1;
  wire [SPW-1:0] sp_plus = sp_q + 1'b1;
  wire [7:0] pop_val = stack_q[sp_plus];

  // shifter and the three bit modifiers
  logic [7:0] sh_res;
  logic sh_cout;
  logic [7:0] io_res;
  logic [7:0] bld_res;
  logic [7:0] flag_res;

  shift_unit #(.W(8)) u_shift (
    .val(rd_val),
    .cin(flags_q[`FLAG_BORROW]),
    .op(op),
    .res(sh_res),
    .cout(sh_cout)
  );

  bit_modify #(.W(8)) u_io_bit (
    .val(io_val),
    .idx(ins_q.bit_sel),
    .fill(op == io_bit_set_op),
    .res(io_res)
  );

  bit_modify #(.W(8)) u_reg_bit (
    .val(rd_val),
    .idx(ins_q.bit_sel),
    .fill(flags_q[`FLAG_COPY]),
    .res(bld_res)
  );

  // flag index and fill per op; only one flag bit ever changes
  wire gen_flag = op inside {flag_set_op, flag_clear_op};
  wire msb_flag = op inside {msb_flag_set_op, msb_flag_clear_op};
  wire low_flag = op inside {all_low_set_op, all_low_clear_op};
  wire rot_op = op inside {rotate_left_op, rotate_right_op};
  wire [2:0] flag_idx = gen_flag ? ins_q.bit_sel :
    op == reg_to_copy_flag_op ? `FLAG_COPY :
    msb_flag ? `FLAG_MSB :
    low_flag ? `FLAG_ALL_LOW : `FLAG_BORROW;
  wire flag_fill = op inside {flag_set_op, borrow_flag_set_op,
    msb_flag_set_op, all_low_set_op} ? 1'b1 :
    op == reg_to_copy_flag_op ? rr_val[ins_q.bit_sel] :
    rot_op ? sh_cout : 1'b0;

  bit_modify #(.W(8)) u_flag_bit (
    .val(flags_q),
    .idx(flag_idx),
    .fill(flag_fill),
    .res(flag_res)
  );

  // exec write enables
  wire flag_we = commit && (rot_op ||
    op inside {[flag_set_op:all_low_clear_op]});
  wire x_gpr_we = commit && op inside {stack_load_op,
    [shift_left_op:copy_flag_to_reg_op]};
  wire [7:0] x_gpr_data = op == stack_load_op ? pop_val :
    op == copy_flag_to_reg_op ? bld_res : sh_res;
  wire x_io_we = commit && op inside {io_bit_set_op, io_bit_clear_op};
  wire push_we = commit && op == stack_store_op;
  wire pop_we = commit && op == stack_load_op;

  // exec and software share one write port per array
  wire gpr_we = x_gpr_we | sw_gpr_we;
  wire [4:0] gpr_widx = busy ? ins_q.rd : wb_idx;
  wire [7:0] gpr_wdata = busy ? x_gpr_data : WB_DAT_I[7:0];
  wire io_we = x_io_we | sw_io_we;
  wire [4:0] io_widx = busy ? ins_q.io_addr : wb_idx;
  wire [7:0] io_wdata = busy ? io_res : WB_DAT_I[7:0];

  // control fsm: load count at start, retire when it reaches zero
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_q <= st_idle;
      cnt_q <= 2'h0;
      ins_q <= '0;
    end else begin
      case (state_q)
        st_idle: begin
          if (start) begin
            state_q <= st_exec;
            cnt_q <= cnt_load;
            ins_q <= new_ins;
          end
        end
        st_exec: begin
          if (commit) begin
            state_q <= st_idle;
          end else begin
            cnt_q <= cnt_q - 2'h1;
          end
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  // register arrays
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      for (int i = 0; i < 32; i++) begin
        gpr_q[i] <= `REG_RESET;
        io_q[i] <= `REG_RESET;
      end
    end else begin
      if (gpr_we) gpr_q[gpr_widx] <= gpr_wdata;
      if (io_we) io_q[io_widx] <= io_wdata;
    end
  end

  // status flags
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      flags_q <= `FLAGS_RESET;
    end else if (flag_we) begin
      flags_q <= flag_res;
    end else if (sw_flags_we) begin
      flags_q <= WB_DAT_I[7:0];
    end
  end

  // stack grows downward; no guard, the pointer simply wraps
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sp_q <= SPW'(STACK_DEPTH - 1);
    end else if (push_we) begin
      sp_q <= sp_minus;
    end else if (pop_we) begin
      sp_q <= sp_plus;
    end
  end

  // stack storage needs no reset
  always_ff @(posedge CLK_SYS) begin
    if (push_we) stack_q[sp_q] <= rr_val;
  end

  // read data; unmapped words read zero and are still acked
  wire [31:0] rd_word = sel_instr ? 32'(ins_q) :
    sel_status ? 32'(busy) :
    sel_flags ? 32'(flags_q) :
    sel_sp ? 32'(sp_q) :
    sel_gpr ? 32'(gpr_q[wb_idx]) :
    sel_io ? 32'(io_q[wb_idx]) : 32'h0000_0000;

  // one wait state: ack registered, dropped the cycle after
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) dat_q <= rd_word;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;
  assign BUSY = busy;

  // helper copies of the operands for the checks below
  logic [7:0] rd_prev_q;
  logic [7:0] rr_prev_q;
  logic [7:0] io_prev_q;
  logic [7:0] flags_prev_q;
  logic [7:0] pop_prev_q;
  logic [SPW-1:0] sp_prev_q;
  always_ff @(posedge CLK_SYS) begin
    rd_prev_q <= rd_val;
    rr_prev_q <= rr_val;
    io_prev_q <= io_val;
    flags_prev_q <= flags_q;
    pop_prev_q <= pop_val;
    sp_prev_q <= sp_q;
  end
  wire [7:0] io_mask = 8'h01 << ins_q.bit_sel;
  wire [7:0] flag_mask = 8'h01 << flag_idx;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence seq_two(op_type o);
    start && new_ins.op == o ##1 busy && !commit ##1 commit;
  endsequence
  sequence seq_one(op_type o);
    start && new_ins.op == o ##1 commit;
  endsequence

  AST_PUSH_TWO: assert property (
    seq_two(stack_store_op) |=> !busy && sp_q == sp_prev_q - 1'b1 &&
      stack_q[sp_prev_q] == rr_prev_q)
    else $error("stack store wrong or not two cycles");
  AST_POP_TWO: assert property (
    seq_two(stack_load_op) |=> !busy && gpr_q[ins_q.rd] == pop_prev_q)
    else $error("stack load wrong or not two cycles");
  AST_IO_SET: assert property (
    seq_two(io_bit_set_op) |=>
      io_q[ins_q.io_addr] == (io_prev_q | io_mask))
    else $error("i/o bit set wrong");
  AST_IO_CLR: assert property (
    commit && op == io_bit_clear_op |=>
      io_q[ins_q.io_addr] == (io_prev_q & ~io_mask))
    else $error("i/o bit clear wrong");
  AST_SHL: assert property (
    seq_one(shift_left_op) |=> !busy &&
      gpr_q[ins_q.rd] == {rd_prev_q[6:0], 1'b0})
    else $error("left shift wrong");
  AST_SHR: assert property (
    commit && op == shift_right_op |=>
      gpr_q[ins_q.rd] == {1'b0, rd_prev_q[7:1]})
    else $error("right shift wrong");
  AST_ROL: assert property (
    commit && op == rotate_left_op |=> flags_q[`FLAG_BORROW] ==
      rd_prev_q[7] && gpr_q[ins_q.rd] ==
      {rd_prev_q[6:0], flags_prev_q[`FLAG_BORROW]})
    else $error("rotate left wrong");
  AST_ROR: assert property (
    commit && op == rotate_right_op |=> flags_q[`FLAG_BORROW] ==
      rd_prev_q[0] && gpr_q[ins_q.rd] ==
      {flags_prev_q[`FLAG_BORROW], rd_prev_q[7:1]})
    else $error("rotate right wrong");
  AST_ASR: assert property (
    commit && op == sign_shift_right_op |=>
      gpr_q[ins_q.rd] == {rd_prev_q[7], rd_prev_q[7:1]})
    else $error("sign shift wrong");
  AST_SWAP: assert property (
    commit && op == nibble_swap_op |=>
      gpr_q[ins_q.rd] == {rd_prev_q[3:0], rd_prev_q[7:4]})
    else $error("nibble swap wrong");
  AST_FLAG_GEN: assert property (
    commit && gen_flag |=>
      flags_q[ins_q.bit_sel] == (ins_q.op == flag_set_op))
    else $error("flag set or clear wrong");
  AST_BST: assert property (
    commit && op == reg_to_copy_flag_op |=>
      flags_q[`FLAG_COPY] == rr_prev_q[ins_q.bit_sel])
    else $error("copy flag not loaded");
  AST_BLD: assert property (
    commit && op == copy_flag_to_reg_op |=> gpr_q[ins_q.rd] ==
      ((rd_prev_q & ~io_mask) |
      (flags_prev_q[`FLAG_COPY] ? io_mask : 8'h00)))
    else $error("register bit not loaded from copy flag");
  AST_BORROW: assert property (
    seq_one(borrow_flag_set_op) or seq_one(borrow_flag_clear_op) |=>
      !busy && flags_q[`FLAG_BORROW] == (ins_q.op == borrow_flag_set_op))
    else $error("borrow flag not forced");
  AST_MSB: assert property (
    commit && msb_flag |=>
      flags_q[`FLAG_MSB] == (ins_q.op == msb_flag_set_op))
    else $error("msb flag not forced");
  AST_LOW: assert property (
    commit && low_flag |=>
      flags_q[`FLAG_ALL_LOW] == (ins_q.op == all_low_set_op))
    else $error("zero-result flag not forced");
  AST_ONE_FLAG: assert property (
    commit && op inside {[flag_set_op:all_low_clear_op]} ##1 1'b1
      |-> ((flags_q ^ flags_prev_q) & ~$past(flag_mask)) == 8'h00 &&
      $stable(gpr_q[ins_q.rd]))
    else $error("single-flag op disturbed other state");

endmodule // bit_shift_flag_unit
`default_nettype wire

// ---- test_bit_shift_flag_unit.sv ----
// self-checking bench for the bit, shift and flag execution unit
`include "bsfu_params.svh"
`default_nettype none
module test_bit_shift_flag_unit
  import bsfu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [8:0] adr = 9'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack;
  logic busy;
  int error_cnt = 0;
  int total_checks = 0;
  logic [31:0] lfsr_q = 32'h0001_051A;
  logic [40:0] exp_q[$];
  logic [40:0] item;

  bit_shift_flag_unit #(.STACK_DEPTH(16)) uut (
    .CLK_SYS(clk_sys),
    .RST(rst),
    .WB_CYC_I(cyc),
    .WB_STB_I(stb),
    .WB_WE_I(we),
    .WB_ADR_I(adr),
    .WB_SEL_I(sel),
    .WB_DAT_I(dat_i),
    .WB_DAT_O(dat_o),
    .WB_ACK_O(ack),
    .BUSY(busy)
  );

  // 200 mhz core clock
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // fixed-seed lfsr so every run drives the same values
  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction

  // reference shifter, returns {borrow, result}
  function automatic logic [8:0] shf(input logic [4:0] op,
                                     input logic [7:0] v, input logic c);
    case (op)
      5'h04: return {c, v[6:0], 1'b0};
      5'h05: return {c, 1'b0, v[7:1]};
      5'h06: return {v[7], v[6:0], c};
      5'h07: return {v[0], c, v[7:1]};
      5'h08: return {c, v[7], v[7:1]};
      default: return {c, v[3:0], v[7:4]};
    endcase
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [8:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_i <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 50);
    check("bus ack", {31'h0, ack}, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // note the expectation, the monitor compares when ack shows
  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    exp_q.push_back({a, e});
    wb(1'b0, a, 32'h0000_0000, 4'hF);
  endtask

  // issue one instruction and count the cycles busy stays high
  task automatic ex(input op_type op, input logic [4:0] d,
                    input logic [4:0] r, input logic [2:0] b,
                    input logic [4:0] io, input int cyc_n);
    int n;
    n = 0;
    wb(1'b1, `ADR_INSTR, {9'h0, op, d, r, b, io}, 4'hF);
    forever begin
      @(posedge clk_sys);
      if (busy !== 1'b1 || n > 8) break;
      n++;
    end
    check("busy cycles", 32'(n), 32'(cyc_n));
  endtask

  // read monitor: oldest note against the data seen with ack
  always @(posedge clk_sys) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0) begin
        check("unexpected read", 32'h1, 32'h0);
      end else begin
        item = exp_q.pop_front();
        check($sformatf("read %h", item[40:32]), dat_o, item[31:0]);
      end
    end
  end

  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end

  initial begin
    logic [31:0] r;
    logic [31:0] v;
    logic [8:0] e;
    logic [7:0] m;
    logic [2:0] p;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    // reset state, unmapped place, refused byte lane
    rd(`ADR_FLAGS, 32'h0000_0000);
    rd(`ADR_SP, 32'h0000_000F);
    rd(`ADR_STATUS, 32'h0000_0000);
    wb(1'b1, 9'h010, 32'h0000_00FF, 4'hF);
    rd(9'h010, 32'h0000_0000);
    wb(1'b1, 9'h090, 32'h0000_00A5, 4'hE);
    rd(9'h090, 32'h0000_0000);
    // every shift kind, random data and borrow, gpr 3
    for (int k = 4; k <= 9; k++) begin
      r = rnd();
      wb(1'b1, `ADR_FLAGS, {31'h0, r[8]}, 4'hF);
      wb(1'b1, 9'h08C, {24'h0, r[7:0]}, 4'hF);
      ex(op_type'(k[4:0]), 5'd3, 5'd0, 3'd0, 5'd0, 1);
      e = shf(k[4:0], r[7:0], r[8]);
      rd(9'h08C, {24'h0, e[7:0]});
      rd(`ADR_FLAGS, {31'h0, e[8]});
    end
    // generic flag set and clear on each of the eight positions
    for (int s = 0; s < 8; s++) begin
      r = rnd();
      wb(1'b1, `ADR_FLAGS, {24'h0, r[7:0]}, 4'hF);
      ex(flag_set_op, 5'd0, 5'd0, s[2:0], 5'd0, 1);
      rd(`ADR_FLAGS, {24'h0, r[7:0] | (8'h01 << s)});
      ex(flag_clear_op, 5'd0, 5'd0, s[2:0], 5'd0, 1);
      rd(`ADR_FLAGS, {24'h0, r[7:0] & ~(8'h01 << s)});
    end
    // dedicated flag ops, other flags and gpr 7 must not move
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      wb(1'b1, `ADR_FLAGS, {24'h0, r[7:0]}, 4'hF);
      wb(1'b1, 9'h09C, {24'h0, r[15:8]}, 4'hF);
      p = (k < 2) ? `FLAG_BORROW : (k < 4) ? `FLAG_MSB : `FLAG_ALL_LOW;
      m = r[7:0];
      m[p] = ~k[0];
      ex(op_type'(5'd14 + k[4:0]), 5'd7, 5'd7, 3'd7, 5'd7, 1);
      rd(`ADR_FLAGS, {24'h0, m});
      rd(9'h09C, {24'h0, r[15:8]});
    end
    // bit to copy flag and back into another register
    r = rnd();
    v = rnd();
    wb(1'b1, `ADR_FLAGS, 32'h0000_0000, 4'hF);
    wb(1'b1, 9'h094, {24'h0, r[7:0]}, 4'hF);
    wb(1'b1, 9'h098, {24'h0, v[7:0]}, 4'hF);
    ex(reg_to_copy_flag_op, 5'd0, 5'd5, r[10:8], 5'd0, 1);
    m = 8'h00;
    m[`FLAG_COPY] = r[r[10:8]];
    rd(`ADR_FLAGS, {24'h0, m});
    ex(copy_flag_to_reg_op, 5'd6, 5'd0, v[10:8], 5'd0, 1);
    m = v[7:0];
    m[v[10:8]] = r[r[10:8]];
    rd(9'h098, {24'h0, m});
    // push then pop into a different register
    wb(1'b1, 9'h084, {24'h0, r[23:16]}, 4'hF);
    ex(stack_store_op, 5'd0, 5'd1, 3'd0, 5'd0, 2);
    rd(`ADR_SP, 32'h0000_000E);
    ex(stack_load_op, 5'd2, 5'd0, 3'd0, 5'd0, 2);
    rd(9'h088, {24'h0, r[23:16]});
    rd(`ADR_SP, 32'h0000_000F);
    // i/o bit set and clear on one register
    wb(1'b1, 9'h124, {24'h0, v[23:16]}, 4'hF);
    ex(io_bit_set_op, 5'd0, 5'd0, v[26:24], 5'd9, 2);
    m = v[23:16];
    m[v[26:24]] = 1'b1;
    rd(9'h124, {24'h0, m});
    ex(io_bit_clear_op, 5'd0, 5'd0, v[29:27], 5'd9, 2);
    m[v[29:27]] = 1'b0;
    rd(9'h124, {24'h0, m});
    // busy seen on status mid-op; a later instruction missing lane 2
    // is dropped (a classic cycle cannot land while a 2-cycle op runs)
    wb(1'b1, `ADR_INSTR, {9'h0, io_bit_set_op, 10'h0, 3'd0, 5'd10}, 4'hF);
    rd(`ADR_STATUS, 32'h0000_0001);
    wb(1'b1, `ADR_INSTR, {9'h0, flag_set_op, 10'h0, 3'd0, 5'd0}, 4'h3);
    repeat (4) @(posedge clk_sys);
    rd(`ADR_FLAGS, {25'h0, r[r[10:8]], 6'h0});
    rd(9'h128, 32'h0000_0001);
    repeat (3) @(posedge clk_sys);
    check("pending reads", 32'(exp_q.size()), 32'h0);
    finish_test();
  end
endmodule // test_bit_shift_flag_unit
`default_nettype wire
